// file: design/lpm_pkg.sv
// constants shared by both ends of the low-power mode controller
// assumes one clock, pclk, also used as the crystal clock count base
package lpm_pkg;
    // apb register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PLL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    // control register bit positions
    localparam int B_OSC_RUN = 0;
    localparam int B_SHORT_REC = 1;
    localparam int B_HALT_EN = 2;
    localparam int B_SUP_EN = 3;
    localparam int B_TICK_EN = 4;
    localparam int B_SUP_RST = 5;
    localparam int B_BREAK_EN = 6;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RST = 7'h7C;
    // pll register bits
    localparam int B_BASE_SEL = 0;
    localparam int B_PLL_PWR = 1;
    // status register bits (break flag and serial invalid are write-one-clear, mask is read-only)
    localparam int B_BREAK_FLAG = 0;
    localparam int B_MASK = 1;
    localparam int B_SER_BAD = 2;
    localparam int B_STATE = 4;
    // recovery lengths and watchdog service period in crystal cycles
    localparam int REC_LONG = 4096;
    localparam int REC_SHORT = 32;
    localparam int WDOG_SERVICE = 1024;
    // controller state
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_STBY = 4'b0010,
        ST_HALT = 4'b0100,
        ST_RECOV = 4'b1000
    } lpm_state_e;
endpackage

// file: design/lpm_if.sv
// link between the processor core end and the low-power controller end
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface lpm_if;
    logic standby_op; // core: standby opcode executed, pulse
    logic halt_op; // core: halt opcode executed, pulse
    logic conv_chan_off; // core: converter powered down, level
    logic pll_release; // core: clear base select and pll power, pulse
    logic wdog_service; // core: watchdog clear, pulse
    logic core_clk_run; // dev: core clock enable, level
    logic irq_mask; // dev: core interrupt mask flag
    logic break_flag; // dev: break during standby or halt flag
    logic wake_irq; // dev: woken by interrupt, pulse
    logic wake_reset; // dev: woken by reset, pulse
    modport dev (
        input standby_op, halt_op, conv_chan_off, pll_release, wdog_service,
        output core_clk_run, irq_mask, break_flag, wake_irq, wake_reset
    );
    modport core (
        output standby_op, halt_op, conv_chan_off, pll_release, wdog_service,
        input core_clk_run, irq_mask, break_flag, wake_irq, wake_reset
    );
endinterface

// file: design/lpm_core.sv
// core-side end: issues low-power opcodes and keeps software duties
// assumes the controller end gates this end through core_clk_run
`timescale 1ns/1ps
module lpm_core
    import lpm_pkg::*;
#(
    parameter int SERVICE_PERIOD = WDOG_SERVICE
)(
    input wire logic pclk,
    input wire logic presetn,
    lpm_if.core lnk,
    input wire logic exec_standby,
    input wire logic exec_halt,
    input wire logic conv_wake_needed,
    input wire logic pll_off_req,
    input wire logic [15:0] ret_addr,
    output logic [15:0] ret_addr_adj,
    output logic core_busy,
    output logic interrupts_enabled
);
    initial
    begin
        if (SERVICE_PERIOD < 2 || SERVICE_PERIOD > 65535)
            $error("service period out of range");
    end

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_PREP = 3'b010,
        CS_WAIT = 3'b100
    } lpm_cst_e;

    typedef struct packed {
        lpm_cst_e st; // opcode sequencer
        logic halt; // pending opcode is halt
        logic sop; // standby opcode pulse
        logic hop; // halt opcode pulse
        logic chan_off; // converter power-down level
        logic pll_rel; // pll release pulse
        logic svc; // watchdog service pulse
        logic [15:0] cnt; // service interval counter
        logic [15:0] radj; // adjusted return address
    } lpm_core_s;

    lpm_core_s s, next_s;

    ////////////////////////////////////////////////////////////////
    // sequencer: prepare, issue opcode, wait for clock back
    always_comb
    begin
        next_s = s;
        next_s.sop = 1'b0;
        next_s.hop = 1'b0;
        next_s.pll_rel = 1'b0;
        next_s.svc = 1'b0;
        next_s.radj = lnk.break_flag ? ret_addr - 16'h0001 : ret_addr;
        unique case (s.st)
            CS_IDLE:
            begin
                if (exec_standby || exec_halt)
                begin
                    next_s.halt = exec_halt;
                    next_s.chan_off = !conv_wake_needed;
                    next_s.pll_rel = pll_off_req && !exec_halt;
                    next_s.st = CS_PREP;
                end
            end
            CS_PREP:
            begin
                // settings took effect last cycle, now issue
                next_s.sop = !s.halt;
                next_s.hop = s.halt;
                next_s.cnt = 16'h0000;
                next_s.st = CS_WAIT;
            end
            CS_WAIT:
            begin
                // the opcode pulse cycle still sees the old clock state
                if (!s.sop && !s.hop && lnk.core_clk_run)
                begin
                    next_s.chan_off = 1'b0;
                    next_s.st = CS_IDLE;
                end
                else if (!s.halt)
                begin
                    next_s.cnt = s.cnt + 16'h0001;
                    if (s.cnt == 16'(SERVICE_PERIOD - 1))
                    begin
                        next_s.cnt = 16'h0000;
                        next_s.svc = 1'b1;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.st <= CS_IDLE;
        end
        else
            s <= next_s;
    end

    assign lnk.standby_op = s.sop;
    assign lnk.halt_op = s.hop;
    assign lnk.conv_chan_off = s.chan_off;
    assign lnk.pll_release = s.pll_rel;
    assign lnk.wdog_service = s.svc;
    assign ret_addr_adj = s.radj;
    assign core_busy = (s.st != CS_IDLE);
    assign interrupts_enabled = !lnk.irq_mask;
endmodule

// file: design/lpm_device.sv
// low-power controller end: standby and halt sequencing, clock gating,
// per-module enables, wake and recovery, apb control registers
// assumes wake sources from same-clock logic, except the external and
// keypad requests, which are pins and get synchronised here
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module lpm_device
    import lpm_pkg::*;
#(
    parameter int REC_LONG_CYC = REC_LONG,
    parameter int REC_SHORT_CYC = REC_SHORT
)(
    input wire logic pclk,
    input wire logic presetn,
    lpm_if.dev lnk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin,
    input wire logic kbd_irq_pin,
    input wire logic external_irq_mask,
    input wire logic keypad_irq_mask,
    input wire logic conv_irq,
    input wire logic break_irq,
    input wire logic ser_irq,
    input wire logic ser_busy,
    input wire logic sup_reset,
    output logic core_clk_en,
    output logic bus_clk_en,
    output logic osc_en,
    output logic pll_en,
    output logic base_clock_select,
    output logic crystal_clock_output_en,
    output logic generator_clock_output_en,
    output logic generator_interrupt_output_en,
    output logic conv_active,
    output logic conv_powered,
    output logic conv_abort,
    output logic conv_settle,
    output logic break_active,
    output logic wdog_clk_en,
    output logic wdog_prescaler_clr,
    output logic wdog_clear,
    output logic ser_active,
    output logic supply_monitor_en,
    output logic tick_en,
    output logic sys_reset_req
);
    initial
    begin
        if (REC_LONG_CYC < 1 || REC_LONG_CYC > 4096 || REC_SHORT_CYC < 1
            || REC_SHORT_CYC > REC_LONG_CYC)
            $error("recovery counts out of range");
    end

    typedef struct packed {
        lpm_state_e st; // controller state
        logic [CTRL_W-1:0] ctrl; // option register
        logic base_sel; // base clock select
        logic pll_pwr; // pll power bit
        logic break_flag; // break during standby or halt flag
        logic mask; // core interrupt mask flag
        logic ser_bad; // serial transfer cut by halt
        logic [11:0] rcnt; // recovery counter
        logic [2:0] ext_s; // external pin synchroniser
        logic [2:0] kbd_s; // keypad pin synchroniser
        logic ext_f; // filtered external request
        logic kbd_f; // filtered keypad request
        logic abort; // conversion abort pulse
        logic settle; // converter settle pulse
        logic wdclr; // prescaler clear pulse
        logic svc; // watchdog clear pulse
        logic wk_irq; // wake by interrupt pulse
        logic wk_rst; // wake by reset pulse
        logic [31:0] rdata; // apb read data
        logic err; // apb error answer
    } lpm_dev_s;

    lpm_dev_s s, next_s;

    // address decode shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_PLL || a == OFS_STAT;
    endfunction

    logic wr_acc;
    logic ext_ok;
    logic kbd_ok;
    logic sup_ok;
    logic stby_wake;
    logic halt_wake;
    logic [11:0] rec_len;

    assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
    assign ext_ok = s.ext_f && !external_irq_mask;
    assign kbd_ok = s.kbd_f && !keypad_irq_mask;
    assign sup_ok = sup_reset && s.ctrl[B_SUP_EN] && s.ctrl[B_SUP_RST];
    assign stby_wake = conv_irq || ser_irq || ext_ok || kbd_ok
        || (break_irq && s.ctrl[B_BREAK_EN]);
    assign halt_wake = ext_ok || kbd_ok || break_irq;
    assign rec_len = s.ctrl[B_SHORT_REC] ? 12'(REC_SHORT_CYC - 1)
        : 12'(REC_LONG_CYC - 1);

    ////////////////////////////////////////////////////////////////
    // next state: synchronisers, mode sequencing, register writes
    always_comb
    begin
        next_s = s;
        next_s.abort = 1'b0;
        next_s.settle = 1'b0;
        next_s.wdclr = 1'b0;
        next_s.wk_irq = 1'b0;
        next_s.wk_rst = 1'b0;
        next_s.svc = lnk.wdog_service;
        next_s.err = 1'b0;
        // pins pass three flops; a change counts when flops two and three agree
        next_s.ext_s = {s.ext_s[1:0], ext_irq_pin};
        next_s.kbd_s = {s.kbd_s[1:0], kbd_irq_pin};
        if (s.ext_s[1] == s.ext_s[2])
            next_s.ext_f = s.ext_s[2];
        if (s.kbd_s[1] == s.kbd_s[2])
            next_s.kbd_f = s.kbd_s[2];
        // software writes first, so hardware sets below win over clears
        if (wr_acc)
        begin
            unique case (paddr)
                OFS_CTRL: next_s.ctrl = pwdata[CTRL_W-1:0];
                OFS_PLL:
                begin
                    next_s.base_sel = pwdata[B_BASE_SEL];
                    next_s.pll_pwr = pwdata[B_PLL_PWR];
                end
                default:
                begin
                    if (pwdata[B_BREAK_FLAG])
                        next_s.break_flag = 1'b0;
                    if (pwdata[B_SER_BAD])
                        next_s.ser_bad = 1'b0;
                end
            endcase
        end
        if (lnk.pll_release)
        begin
            next_s.base_sel = 1'b0;
            next_s.pll_pwr = 1'b0;
        end
        unique case (s.st)
            ST_RUN:
            begin
                if (lnk.standby_op)
                begin
                    next_s.mask = 1'b0;
                    next_s.st = ST_STBY;
                end
                // halt opcode honoured only when enabled
                else if (lnk.halt_op && s.ctrl[B_HALT_EN])
                begin
                    next_s.mask = 1'b0;
                    next_s.abort = 1'b1;
                    next_s.wdclr = 1'b1;
                    // drop vco, fall back to crystal
                    next_s.base_sel = 1'b0;
                    if (ser_busy)
                        next_s.ser_bad = 1'b1;
                    next_s.st = ST_HALT;
                end
            end
            ST_STBY:
            begin
                if (sup_ok)
                begin
                    next_s.mask = 1'b1;
                    next_s.wk_rst = 1'b1;
                    next_s.st = ST_RUN;
                end
                else if (stby_wake)
                begin
                    if (break_irq && s.ctrl[B_BREAK_EN])
                        next_s.break_flag = 1'b1;
                    next_s.wk_irq = 1'b1;
                    next_s.st = ST_RUN;
                end
            end
            ST_HALT:
            begin
                if (sup_ok || halt_wake)
                begin
                    next_s.mask = sup_ok ? 1'b1 : s.mask;
                    next_s.wk_rst = sup_ok;
                    if (break_irq && !sup_ok)
                        next_s.break_flag = 1'b1;
                    next_s.settle = !sup_ok && (ext_ok || kbd_ok);
                    next_s.rcnt = rec_len;
                    next_s.st = ST_RECOV;
                end
            end
            ST_RECOV:
            begin
                if (s.rcnt == 12'h000)
                begin
                    next_s.wk_irq = !s.wk_rst;
                    next_s.st = ST_RUN;
                end
                else
                    next_s.rcnt = s.rcnt - 12'h001;
                // kept through recovery so it shows in the first run cycle
                next_s.wk_rst = s.wk_rst;
            end
        endcase
        // read data captured at the setup cycle
        if (psel && !penable)
        begin
            next_s.rdata = 32'h00000000;
            next_s.err = !is_mapped(paddr);
            if (paddr == OFS_CTRL)
                next_s.rdata[CTRL_W-1:0] = s.ctrl;
            else if (paddr == OFS_PLL)
                next_s.rdata[B_PLL_PWR:B_BASE_SEL] = {s.pll_pwr, s.base_sel};
            else if (paddr == OFS_STAT)
                next_s.rdata[B_STATE+3:0] = {s.st, 1'b0, s.ser_bad, s.mask, s.break_flag};
        end
        else if (psel)
            next_s.err = s.err;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.st <= ST_RUN;
            s.ctrl <= CTRL_RST;
            s.mask <= 1'b1;
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////
    // outputs decoded from registered state
    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && s.err;
    assign lnk.core_clk_run = (s.st == ST_RUN);
    assign lnk.irq_mask = s.mask;
    assign lnk.break_flag = s.break_flag;
    assign lnk.wake_irq = s.wk_irq;
    assign lnk.wake_reset = s.wk_rst && s.st == ST_RUN;
    assign core_clk_en = (s.st == ST_RUN);
    // bus clock stops in halt unless osc bit, and throughout recovery
    assign bus_clk_en = s.st == ST_RUN || s.st == ST_STBY
        || (s.st == ST_HALT && s.ctrl[B_OSC_RUN]);
    // oscillator off in halt by default
    assign osc_en = s.st != ST_HALT || s.ctrl[B_OSC_RUN];
    // pll off throughout halt and recovery
    assign pll_en = s.pll_pwr && s.st != ST_HALT && s.st != ST_RECOV;
    assign base_clock_select = s.base_sel;
    assign crystal_clock_output_en = osc_en;
    assign generator_clock_output_en = osc_en && s.st != ST_RECOV;
    assign generator_interrupt_output_en = osc_en && s.st != ST_RECOV;
    assign conv_active = s.st == ST_RUN || s.st == ST_STBY;
    assign conv_powered = conv_active && !lnk.conv_chan_off;
    assign conv_abort = s.abort;
    assign conv_settle = s.settle;
    assign break_active = s.ctrl[B_BREAK_EN] && (s.st == ST_RUN || s.st == ST_STBY);
    assign wdog_clk_en = s.st != ST_HALT;
    assign wdog_prescaler_clr = s.wdclr;
    assign wdog_clear = s.svc;
    assign ser_active = s.st != ST_HALT && s.st != ST_RECOV;
    // option bits for monitor and tick
    assign supply_monitor_en = s.ctrl[B_SUP_EN];
    assign tick_en = s.ctrl[B_TICK_EN] && s.st != ST_HALT;
    assign sys_reset_req = lnk.wake_reset;
endmodule

// file: tb/lpm_link_chk.sv
// checker on the link: clock gating, mask and wake pulses
// assumes one clock; inputs are the interface signals themselves
`timescale 1ns/1ps
module lpm_link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby_op,
    input wire logic halt_op,
    input wire logic core_clk_run,
    input wire logic irq_mask,
    input wire logic wake_irq,
    input wire logic wake_reset
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////
    chk_stby_clk_off: assert property (standby_op && core_clk_run |=> !core_clk_run)
        else $error("core clock kept after standby");
    chk_stby_mask_clr: assert property (standby_op && core_clk_run |-> ##[1:2] !irq_mask)
        else $error("mask not cleared by standby");
    // one halt cycle plus the shortest recovery keeps the core off five cycles at least
    chk_halt_hold_off:
        assert property ($fell(core_clk_run) && $past(halt_op) |-> !core_clk_run [*5])
        else $error("halt recovery too short");
    chk_wake_clk_on: assert property ($rose(core_clk_run) |-> wake_irq || wake_reset)
        else $error("core clock back without wake");
    chk_wake_irq_run: assert property (wake_irq |-> core_clk_run && !irq_mask)
        else $error("interrupt wake with mask set");
    chk_wake_rst_mask: assert property (wake_reset |-> ##[0:2] irq_mask)
        else $error("reset wake left mask clear");
    chk_wake_one_pulse: assert property (wake_irq |=> !wake_irq)
        else $error("wake pulse too long");
    chk_wake_kind_excl: assert property (!(wake_irq && wake_reset))
        else $error("two wake kinds at once");
    chk_op_only_run: assert property (standby_op || halt_op |-> core_clk_run)
        else $error("opcode with core stopped");
    ////////////////////////
    cov_stby: cover property (standby_op ##1 !core_clk_run);
    cov_halt_wake: cover property ($fell(core_clk_run) && $past(halt_op) ##[5:300] wake_irq);
    cov_rst_wake: cover property (wake_reset);
endmodule

// file: tb/tb_low_power_mode_controller.sv
// bench: core end and controller end on one link, apb driven here
// assumes zero or more wait states on apb and one clock
`timescale 1ns/1ps
module tb_low_power_mode_controller
    import lpm_pkg::*;
;
    // small recovery counts keep the run short
    localparam int RL = 16;
    localparam int RS = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic exec_standby = 1'b0;
    logic exec_halt = 1'b0;
    logic conv_wake_needed = 1'b1;
    logic pll_off_req = 1'b0;
    logic ser_busy = 1'b0;
    logic ext_msk = 1'b0;
    logic kbd_msk = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] src = 6'h00; // conv, serial, ext, kbd, break, monitor
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, wi, wr;
    logic [15:0] ret_addr_adj;
    logic core_clk_en, bus_clk_en, osc_en, pll_en, base_clock_select, xclk_en;
    logic conv_active, wdog_clk_en, ser_active, supply_monitor_en, tick_en;
    logic wdog_clear, wdog_pclr;
    int svc_seen = 0; // watchdog clear pulses seen
    int pclr_seen = 0; // prescaler clear pulses seen
    int err_total = 0;
    int tests_run = 0;
    int n;
    // bit 6 halt, else standby; bits 5:0 the wake source
    logic [6:0] rows [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h20, 7'h44, 7'h48, 7'h50, 7'h60};
    always #20 pclk = ~pclk;
    // pulse counters for the watchdog side
    always @(posedge pclk)
    begin
        if (wdog_clear === 1'b1)
            svc_seen++;
        if (wdog_pclr === 1'b1)
            pclr_seen++;
    end
    ////////////////////////
    lpm_if lnk();
    lpm_core #(.SERVICE_PERIOD(8)) u_lpm_core (
        .pclk(pclk), .presetn(presetn), .lnk(lnk), .exec_standby(exec_standby),
        .exec_halt(exec_halt), .conv_wake_needed(conv_wake_needed), .pll_off_req(pll_off_req),
        .ret_addr(16'h1234), .ret_addr_adj(ret_addr_adj), .core_busy(), .interrupts_enabled()
    );
    lpm_device #(.REC_LONG_CYC(RL), .REC_SHORT_CYC(RS)) u_lpm_device (
        .pclk(pclk), .presetn(presetn), .lnk(lnk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pin(src[2]), .kbd_irq_pin(src[3]),
        .external_irq_mask(ext_msk), .keypad_irq_mask(kbd_msk), .conv_irq(src[0]),
        .break_irq(src[4]), .ser_irq(src[1]), .ser_busy(ser_busy), .sup_reset(src[5]),
        .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en), .osc_en(osc_en), .pll_en(pll_en),
        .base_clock_select(base_clock_select), .crystal_clock_output_en(xclk_en),
        .generator_clock_output_en(), .generator_interrupt_output_en(),
        .conv_active(conv_active), .conv_powered(), .conv_abort(), .conv_settle(),
        .break_active(), .wdog_clk_en(wdog_clk_en), .wdog_prescaler_clr(wdog_pclr),
        .wdog_clear(wdog_clear),
        .ser_active(ser_active), .supply_monitor_en(supply_monitor_en), .tick_en(tick_en),
        .sys_reset_req()
    );
    lpm_link_chk u_lpm_link_chk (
        .pclk(pclk), .presetn(presetn), .standby_op(lnk.standby_op), .halt_op(lnk.halt_op),
        .core_clk_run(lnk.core_clk_run), .irq_mask(lnk.irq_mask), .wake_irq(lnk.wake_irq),
        .wake_reset(lnk.wake_reset)
    );
    ////////////////////////
    task chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one opcode through the core end, then let it settle
    task enter(input logic h);
        @(posedge pclk);
        exec_halt <= h;
        exec_standby <= !h;
        @(posedge pclk);
        exec_halt <= 1'b0;
        exec_standby <= 1'b0;
        cyc(5);
    endtask
    // raise sources, count cycles until the core clock is back
    task wake(input logic [5:0] s);
        @(posedge pclk);
        src <= s;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (lnk.core_clk_run !== 1'b1 && n < 300);
        wi = lnk.wake_irq;
        wr = lnk.wake_reset;
        @(posedge pclk);
        src <= 6'h00;
    endtask
    task complete_run;
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////
    // the whole sequence needs well under 5000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        $display("[ERR] %0t timeout", $time);
        complete_run;
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            enter(rows[i][6]);
            @(negedge pclk);
            chk(core_clk_en === 1'b0 && lnk.irq_mask === 1'b0, "core or mask");
            chk(bus_clk_en === !rows[i][6] && osc_en === !rows[i][6], "bus or osc");
            chk(wdog_clk_en === !rows[i][6] && ser_active === !rows[i][6], "wdog");
            chk(conv_active === !rows[i][6] && xclk_en === !rows[i][6], "conv");
            wake(rows[i][5:0]);
            chk(wr === rows[i][5] && wi === !rows[i][5], "wake kind");
            chk((n > RL) === rows[i][6], "recovery length");
            cyc(3);
            chk(lnk.irq_mask === rows[i][5], "mask after wake");
            if (rows[i][4])
            begin
                chk(lnk.break_flag === 1'b1 && ret_addr_adj === 16'h1233, "break flag");
                apb(1'b1, OFS_STAT, 32'h1);
            end
        end
        chk(pclr_seen === 4, "prescaler clears");
        // masked pins must not end halt, keypad then does
        ext_msk <= 1'b1;
        kbd_msk <= 1'b1;
        enter(1'b1);
        src <= 6'h0C;
        cyc(40);
        @(negedge pclk);
        chk(lnk.core_clk_run === 1'b0, "masked pin woke");
        @(posedge pclk);
        kbd_msk <= 1'b0;
        wake(6'h0C);
        chk(wi === 1'b1, "keypad wake");
        ext_msk <= 1'b0;
        // halt opcode refused when disabled
        apb(1'b1, OFS_CTRL, 32'h78);
        enter(1'b1);
        @(negedge pclk);
        chk(lnk.core_clk_run === 1'b1, "halt not refused");
        apb(1'b1, OFS_CTRL, 32'h64);
        @(negedge pclk);
        chk(supply_monitor_en === 1'b0 && tick_en === 1'b0, "option bits");
        // oscillator kept, short recovery, pll engaged, serial busy
        apb(1'b1, OFS_CTRL, 32'h7F);
        apb(1'b1, OFS_PLL, 32'h3);
        ser_busy <= 1'b1;
        enter(1'b1);
        @(negedge pclk);
        chk(osc_en === 1'b1 && pll_en === 1'b0 && bus_clk_en === 1'b1, "osc");
        wake(6'h04);
        chk(n > RS && n < RL, "short recovery");
        ser_busy <= 1'b0;
        apb(1'b0, OFS_PLL, 32'h0);
        chk(rd[0] === 1'b0 && base_clock_select === 1'b0, "base select kept");
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rd[2] === 1'b1, "serial flag");
        // standby with pll released and converter off
        apb(1'b1, OFS_PLL, 32'h3);
        pll_off_req <= 1'b1;
        conv_wake_needed <= 1'b0;
        enter(1'b0);
        @(negedge pclk);
        chk(lnk.conv_chan_off === 1'b1, "converter on");
        wake(6'h02);
        apb(1'b0, OFS_PLL, 32'h0);
        chk(rd[1:0] === 2'b00, "pll kept");
        // reset in mid-standby, then reset values
        enter(1'b0);
        n = svc_seen;
        cyc(12);
        chk(svc_seen > n, "no watchdog service");
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(lnk.core_clk_run === 1'b1 && lnk.irq_mask === 1'b1, "reset state");
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd === {25'h0, CTRL_RST}, "control reset");
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rd === 32'h12, "status reset");
        apb(1'b0, 8'h0C, 32'h0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped");
        complete_run;
    end
endmodule
